// ==== rtl/asx_alu_core.sv ====
// Combinational result and flag logic for the five operations
`timescale 1ns/1ps
module asx_alu_core (
  asx_op_if.core port_if
);
  logic [asx_pkg::DATA_W+1:0] sub_res;

  always_comb begin
    sub_res          = asx_pkg::asx_sub(port_if.operand, port_if.acc);
    port_if.result   = asx_pkg::ZERO_BYTE;
    port_if.carry    = asx_pkg::FLAG_RST;
    port_if.nib      = asx_pkg::FLAG_RST;
    port_if.wr_arith = 1'b0;
    port_if.wr_zero  = 1'b0;
    port_if.legal    = 1'b1;
    case (port_if.op)
      // (RULE1) (RULE3) Two's complement subtract
      asx_pkg::OP_LITERAL_MINUS_ACC, asx_pkg::OP_REG_MINUS_ACC: begin
        port_if.result   = sub_res[asx_pkg::DATA_W+1:2];
        port_if.carry    = sub_res[1];
        port_if.nib      = sub_res[0];
        port_if.wr_arith = 1'b1;
        port_if.wr_zero  = 1'b1;
      end
      // (RULE2) (RULE5) Exclusive or, zero flag only
      asx_pkg::OP_LITERAL_PARITY, asx_pkg::OP_REG_PARITY: begin
        port_if.result  = port_if.acc ^ port_if.operand;
        port_if.wr_zero = 1'b1;
      end
      // (RULE6) Nibble exchange, flags untouched
      asx_pkg::OP_NIBBLE_EXCHANGE: begin
        port_if.result = {port_if.operand[asx_pkg::NIB_W-1:0],
                          port_if.operand[asx_pkg::DATA_W-1:asx_pkg::NIB_W]};
      end
      // Unused codes do nothing
      default: begin
        port_if.legal = 1'b0;
      end
    endcase
    port_if.zero = (port_if.result == asx_pkg::ZERO_BYTE);
  end
endmodule : asx_alu_core

// ==== rtl/asx_alu_top.sv ====
// Accumulator, status flags and write-back sequencing of the ALU slice
//
// Operation
// (RULE1) Literal minus accumulator goes to the accumulator and updates borrow, nibble and zero.
// (RULE2) Literal XOR accumulator goes to the accumulator and changes only the zero flag.
// (RULE3) Register minus accumulator sets borrow, nibble and zero, with a 7-bit register index.
// (RULE4) Register operations write the accumulator when target is 0, the register when it is 1.
// (RULE5) Register XOR accumulator goes to the selected target and changes only the zero flag.
// (RULE6) Nibble exchange swaps the register's halves into the target and changes no flag.
// (RULE7) Every operation finishes in one instruction cycle and never asks for a stall.
`timescale 1ns/1ps
module asx_alu_top (
  // Clock and reset
  input  wire logic                       sys_clk_i,
  input  wire logic                       srst_i,
  // Operation request from the decoder
  input  wire logic                       op_valid_i,
  input  wire logic [asx_pkg::OP_W-1:0]   op_code_i,
  input  wire logic [asx_pkg::DATA_W-1:0] literal_i,
  input  wire logic [asx_pkg::IDX_W-1:0]  reg_index_i,
  input  wire logic                       target_sel_i,
  // Data memory read value of the indexed register
  input  wire logic [asx_pkg::DATA_W-1:0] reg_rdata_i,
  // Accumulator and status
  output logic      [asx_pkg::DATA_W-1:0] acc_o,
  output logic                            carry_borrow_o,
  output logic                            nibble_borrow_flag_o,
  output logic                            zero_o,
  // Register write-back
  output logic                            reg_we_o,
  output logic      [asx_pkg::IDX_W-1:0]  reg_waddr_o,
  output logic      [asx_pkg::DATA_W-1:0] reg_wdata_o,
  // Sequencer handshake
  output logic                            done_o,
  output logic                            stall_o
);
  asx_pkg::asx_state_t state_reg;
  asx_pkg::asx_state_t state_next;
  logic                is_reg_op;

  asx_op_if alu_if ();

  asx_alu_core u_core (
    .port_if (alu_if.core)
  );

  always_comb begin
    alu_if.op      = op_code_i;
    // Registered accumulator feeds the next op, so no bypass is needed
    alu_if.acc     = state_reg.acc;
    // Register ops take the register, every other code the literal
    is_reg_op      = (op_code_i == asx_pkg::OP_REG_MINUS_ACC) ||
                     (op_code_i == asx_pkg::OP_REG_PARITY) ||
                     (op_code_i == asx_pkg::OP_NIBBLE_EXCHANGE);
    alu_if.operand = is_reg_op ? reg_rdata_i : literal_i;
  end

  always_comb begin
    state_next        = state_reg;
    // Strobes are pulses; everything else holds until written
    state_next.reg_we = 1'b0;
    state_next.done   = 1'b0;
    // (RULE7) Never stalls
    state_next.stall  = 1'b0;
    // Unused codes fall out here and leave every register alone but the reg_we and done strobes, which clear
    if (op_valid_i && alu_if.legal) begin
      // (RULE7) Single cycle completion
      state_next.done = 1'b1;
      // (RULE4) Target select steers result
      if (is_reg_op && (target_sel_i == asx_pkg::TGT_REG)) begin
        state_next.reg_we    = 1'b1;
        state_next.reg_waddr = reg_index_i;
        state_next.reg_wdata = alu_if.result;
      end else begin
        state_next.acc = alu_if.result;
      end
      // (RULE1) Arithmetic flags on subtract
      if (alu_if.wr_arith) begin
        state_next.carry = alu_if.carry;
        state_next.nib   = alu_if.nib;
      end
      // (RULE2) Zero flag follows result
      if (alu_if.wr_zero) begin
        state_next.zero = alu_if.zero;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    // Outputs clear with the state, so the decoder sees a quiet slice
    if (srst_i) begin
      state_reg.acc       <= asx_pkg::ACC_RST;
      state_reg.carry     <= asx_pkg::FLAG_RST;
      state_reg.nib       <= asx_pkg::FLAG_RST;
      state_reg.zero      <= asx_pkg::FLAG_RST;
      state_reg.reg_we    <= 1'b0;
      state_reg.reg_waddr <= asx_pkg::IDX_RST;
      state_reg.reg_wdata <= asx_pkg::ZERO_BYTE;
      state_reg.done      <= 1'b0;
      state_reg.stall     <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign acc_o                = state_reg.acc;
  assign carry_borrow_o       = state_reg.carry;
  assign nibble_borrow_flag_o = state_reg.nib;
  assign zero_o               = state_reg.zero;
  assign reg_we_o             = state_reg.reg_we;
  assign reg_waddr_o          = state_reg.reg_waddr;
  assign reg_wdata_o          = state_reg.reg_wdata;
  assign done_o               = state_reg.done;
  assign stall_o              = state_reg.stall;

  // Value delivered by the last operation, wherever it went
  logic [asx_pkg::DATA_W-1:0] last_result;
  assign last_result = reg_we_o ? reg_wdata_o : acc_o;

  // One clock for every check; reset masks them while it is held
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);

  AST_LIT_MINUS: assert property ( // (RULE1)
    (op_valid_i && op_code_i == asx_pkg::OP_LITERAL_MINUS_ACC) |=>
      (acc_o == asx_pkg::DATA_W'($past(literal_i) - $past(acc_o))) &&
      (carry_borrow_o == ($past(literal_i) >= $past(acc_o))) &&
      (zero_o == (acc_o == asx_pkg::ZERO_BYTE)))
    else $error("literal minus accumulator result or flags wrong");

  AST_LIT_XOR: assert property ( // (RULE2)
    (op_valid_i && op_code_i == asx_pkg::OP_LITERAL_PARITY) |=>
      (acc_o == ($past(literal_i) ^ $past(acc_o))) && $stable(carry_borrow_o) &&
      $stable(nibble_borrow_flag_o) && (zero_o == (acc_o == asx_pkg::ZERO_BYTE)))
    else $error("literal xor result or flags wrong");

  AST_REG_MINUS: assert property ( // (RULE3)
    (op_valid_i && op_code_i == asx_pkg::OP_REG_MINUS_ACC) |=>
      (last_result == asx_pkg::DATA_W'($past(reg_rdata_i) - $past(acc_o))) &&
      (nibble_borrow_flag_o ==
        ($past(reg_rdata_i[asx_pkg::NIB_W-1:0]) >= $past(acc_o[asx_pkg::NIB_W-1:0]))) &&
      (carry_borrow_o == ($past(reg_rdata_i) >= $past(acc_o))))
    else $error("register minus accumulator result or flags wrong");

  AST_TARGET: assert property ( // (RULE4)
    (op_valid_i && is_reg_op && target_sel_i == asx_pkg::TGT_REG) |=>
      reg_we_o && $stable(acc_o) && (reg_waddr_o == $past(reg_index_i)) ##1
      (!reg_we_o || $past(op_valid_i && is_reg_op && (target_sel_i == asx_pkg::TGT_REG))))
    else $error("register target not written or accumulator disturbed");

  AST_REG_XOR: assert property ( // (RULE5)
    (op_valid_i && op_code_i == asx_pkg::OP_REG_PARITY) |=>
      (last_result == ($past(reg_rdata_i) ^ $past(acc_o))) && $stable(carry_borrow_o) &&
      (zero_o == (last_result == asx_pkg::ZERO_BYTE)))
    else $error("register xor result or flags wrong");

  AST_SWAP: assert property ( // (RULE6)
    (op_valid_i && op_code_i == asx_pkg::OP_NIBBLE_EXCHANGE) |=>
      (last_result == {$past(reg_rdata_i[asx_pkg::NIB_W-1:0]),
                       $past(reg_rdata_i[asx_pkg::DATA_W-1:asx_pkg::NIB_W])}) &&
      $stable(carry_borrow_o) && $stable(nibble_borrow_flag_o) && $stable(zero_o))
    else $error("nibble exchange result wrong or flags changed");

  AST_ONE_CYCLE: assert property ( // (RULE7)
    (op_valid_i && op_code_i <= asx_pkg::OP_NIBBLE_EXCHANGE) |=> done_o && !stall_o)
    else $error("operation did not finish in one cycle");

  // (RULE1) Nibble borrow of a literal subtract
  AST_LIT_NIB: assert property ( // (RULE1)
    (op_valid_i && op_code_i == asx_pkg::OP_LITERAL_MINUS_ACC) |=>
      (nibble_borrow_flag_o ==
        ($past(literal_i[asx_pkg::NIB_W-1:0]) >= $past(acc_o[asx_pkg::NIB_W-1:0]))))
    else $error("literal minus accumulator nibble borrow wrong");

  // (RULE2) Literal ops always land in the accumulator
  AST_LIT_ACC: assert property ( // (RULE2)
    (op_valid_i && ((op_code_i == asx_pkg::OP_LITERAL_PARITY) ||
                    (op_code_i == asx_pkg::OP_LITERAL_MINUS_ACC))) |=> !reg_we_o)
    else $error("literal operation wrote the register side");

  // (RULE3) Zero flag follows the delivered difference
  AST_REG_ZERO: assert property ( // (RULE3)
    (op_valid_i && op_code_i == asx_pkg::OP_REG_MINUS_ACC) |=>
      (zero_o == (last_result == asx_pkg::ZERO_BYTE)))
    else $error("register minus accumulator zero flag wrong");

  // (RULE4) Accumulator target never strobes the memory
  AST_ACC_TARGET: assert property ( // (RULE4)
    (op_valid_i && is_reg_op && target_sel_i == asx_pkg::TGT_ACC) |=>
      !reg_we_o && $stable(reg_waddr_o) && $stable(reg_wdata_o))
    else $error("accumulator target disturbed the register write side");

  // (RULE4) Write strobe only after a register target request
  AST_WE_SOURCE: assert property ( // (RULE4)
    reg_we_o |->
      $past(op_valid_i && is_reg_op && (target_sel_i == asx_pkg::TGT_REG)))
    else $error("register write strobe without a register target request");

  // (RULE5) Register XOR leaves the nibble borrow alone
  AST_REG_XOR_NIB: assert property ( // (RULE5)
    (op_valid_i && op_code_i == asx_pkg::OP_REG_PARITY) |=> $stable(nibble_borrow_flag_o))
    else $error("register xor changed the nibble borrow flag");

  // (RULE7) Unused codes change no accumulator or flag and raise no strobe
  AST_REFUSED: assert property ( // (RULE7)
    (op_valid_i && op_code_i > asx_pkg::OP_NIBBLE_EXCHANGE) |=>
      !done_o && !reg_we_o && $stable(acc_o) && $stable(carry_borrow_o) &&
      $stable(nibble_borrow_flag_o) && $stable(zero_o))
    else $error("unused operation code changed the slice");

  // (RULE7) Done only answers an accepted request
  AST_DONE_SOURCE: assert property ( // (RULE7)
    done_o |-> $past(op_valid_i && (op_code_i <= asx_pkg::OP_NIBBLE_EXCHANGE)))
    else $error("done pulse without an accepted request");

  // Cover points for the main scenarios
  COV_SUB_ZERO: cover property (op_valid_i && op_code_i == asx_pkg::OP_LITERAL_MINUS_ACC ##1
                                zero_o && carry_borrow_o);
  COV_REG_WRITE: cover property (op_valid_i && op_code_i == asx_pkg::OP_REG_PARITY ##1 reg_we_o);
  COV_BACK2BACK: cover property (op_valid_i ##1 op_valid_i && done_o ##1 done_o);
  COV_SWAP_REG: cover property (op_valid_i && op_code_i == asx_pkg::OP_NIBBLE_EXCHANGE &&
                                target_sel_i == asx_pkg::TGT_REG ##1 reg_we_o ##1 reg_we_o);
endmodule : asx_alu_top

// ==== rtl/asx_op_if.sv ====
// Interface carrying one operation between the sequencing top and the ALU core
`timescale 1ns/1ps
interface asx_op_if;
  logic [asx_pkg::OP_W-1:0]   op;
  logic [asx_pkg::DATA_W-1:0] acc;
  logic [asx_pkg::DATA_W-1:0] operand;
  logic [asx_pkg::DATA_W-1:0] result;
  logic                       carry;
  logic                       nib;
  logic                       zero;
  logic                       wr_arith;
  logic                       wr_zero;
  logic                       legal;

  modport core (input op, acc, operand,
                output result, carry, nib, zero, wr_arith, wr_zero, legal);
  modport ctrl (output op, acc, operand,
                input result, carry, nib, zero, wr_arith, wr_zero, legal);
endinterface : asx_op_if

// ==== rtl/asx_pkg.sv ====
// Package with operation codes, widths, reset values and state layout of the ALU slice
package asx_pkg;
  localparam int DATA_W = 8;
  localparam int NIB_W  = 4;
  localparam int IDX_W  = 7;
  localparam int OP_W   = 3;

  localparam logic [DATA_W-1:0] ACC_RST   = 8'h00;
  localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
  localparam logic [IDX_W-1:0]  IDX_RST   = 7'h00;
  localparam logic              FLAG_RST  = 1'b0;
  localparam logic              TGT_ACC   = 1'b0;
  localparam logic              TGT_REG   = 1'b1;

  typedef enum logic [OP_W-1:0] {
    OP_LITERAL_MINUS_ACC = 3'h0,
    OP_LITERAL_PARITY    = 3'h1,
    OP_REG_MINUS_ACC     = 3'h2,
    OP_REG_PARITY        = 3'h3,
    OP_NIBBLE_EXCHANGE   = 3'h4
  } asx_op_t;

  typedef struct packed {
    logic [DATA_W-1:0] acc;
    logic              carry;
    logic              nib;
    logic              zero;
    logic              reg_we;
    logic [IDX_W-1:0]  reg_waddr;
    logic [DATA_W-1:0] reg_wdata;
    logic              done;
    logic              stall;
  } asx_state_t;

  // Subtraction b - a; flags read 1 when no borrow occurred
  function automatic logic [DATA_W+1:0] asx_sub(input logic [DATA_W-1:0] b,
                                                input logic [DATA_W-1:0] a);
    logic [DATA_W-1:0] diff;
    diff = DATA_W'(b - a);
    return {diff, (b >= a), (b[NIB_W-1:0] >= a[NIB_W-1:0])};
  endfunction : asx_sub
endpackage : asx_pkg

// ==== verification/alu_subtract_xor_swap_ops_tb.sv ====
// Self-checking testbench of the ALU slice
`timescale 1ns/1ps
module alu_subtract_xor_swap_ops_tb;
  logic       sys_clk_i = 1'b0, srst_i = 1'b1, op_valid_i = 1'b0, target_sel_i = 1'b0;
  logic [2:0] op_code_i = 3'h0;
  logic [7:0] literal_i = 8'h00, reg_rdata_i, acc_o, reg_wdata_o;
  logic [6:0] reg_index_i = 7'h00, reg_waddr_o;
  logic       carry_borrow_o, nibble_borrow_flag_o, zero_o, reg_we_o, done_o, stall_o;
  int         n_errors = 0, check_count = 0;
  logic [7:0] e_acc = 8'h00, e_wd = 8'h00, sh [128];
  logic [6:0] e_wa = 7'h00;
  logic       e_c = 1'b0, e_dc = 1'b0, e_z = 1'b0;

  initial begin
    forever #20 sys_clk_i = ~sys_clk_i;
  end

  asx_alu_top u_asx_alu_top (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .op_valid_i(op_valid_i),
    .op_code_i(op_code_i), .literal_i(literal_i), .reg_index_i(reg_index_i),
    .target_sel_i(target_sel_i), .reg_rdata_i(reg_rdata_i), .acc_o(acc_o),
    .carry_borrow_o(carry_borrow_o), .nibble_borrow_flag_o(nibble_borrow_flag_o),
    .zero_o(zero_o), .reg_we_o(reg_we_o), .reg_waddr_o(reg_waddr_o),
    .reg_wdata_o(reg_wdata_o), .done_o(done_o), .stall_o(stall_o));
  asx_mem_model u_asx_mem_model (.clk_i(sys_clk_i), .rd_idx_i(reg_index_i),
    .rd_data_o(reg_rdata_i), .we_i(reg_we_o), .waddr_i(reg_waddr_o), .wdata_i(reg_wdata_o));

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // Drives one request at the falling edge and checks the cycle after its edge
  task automatic do_op(input logic [2:0] code, input logic [7:0] lit,
                       input logic [6:0] idx, input logic tgt);
    logic [7:0] b;
    logic [7:0] r;
    logic       wr;
    b = (code < 3'h2) ? lit : sh[idx];
    r = {b[3:0], b[7:4]};
    wr = tgt && code inside {3'h2, 3'h3, 3'h4};
    {op_valid_i, op_code_i, literal_i, reg_index_i, target_sel_i} = {1'b1, code, lit, idx, tgt};
    if (code == 3'h0 || code == 3'h2) begin
      r = b - e_acc;
      e_c = b >= e_acc;
      e_dc = b[3:0] >= e_acc[3:0];
    end
    if (code == 3'h1 || code == 3'h3) r = b ^ e_acc;
    if (code < 3'h4) e_z = (r == 8'h00);
    if (wr) {e_wa, e_wd, sh[idx]} = {idx, r, r};
    else if (code <= 3'h4) e_acc = r;
    @(negedge sys_clk_i);
    chk("done", {7'h00, code <= 3'h4}, done_o);
    chk("stall", 8'h00, stall_o);
    chk("acc", e_acc, acc_o);
    chk("flags", {5'h00, e_c, e_dc, e_z},
        {5'h00, carry_borrow_o, nibble_borrow_flag_o, zero_o});
    chk("we", {7'h00, wr}, reg_we_o);
    chk("waddr", {1'b0, e_wa}, {1'b0, reg_waddr_o});
    chk("wdata", e_wd, reg_wdata_o);
  endtask : do_op

  task automatic t_literal();
    do_op(3'h1, 8'h5a, 7'h00, 1'b1);
    do_op(3'h0, 8'h5a, 7'h00, 1'b0);
    do_op(3'h1, 8'h01, 7'h00, 1'b0);
    do_op(3'h0, 8'h00, 7'h00, 1'b1);
    do_op(3'h1, 8'hff, 7'h00, 1'b0);
    do_op(3'h0, 8'hff, 7'h00, 1'b0);
  endtask : t_literal

  // Back to back, reading a register the previous operation just wrote
  task automatic t_reg();
    do_op(3'h2, 8'h00, 7'h7f, 1'b0);
    do_op(3'h2, 8'h00, 7'h05, 1'b1);
    do_op(3'h2, 8'h00, 7'h05, 1'b0);
    do_op(3'h3, 8'h00, 7'h00, 1'b1);
    do_op(3'h3, 8'h00, 7'h00, 1'b0);
    do_op(3'h3, 8'h00, 7'h7f, 1'b0);
  endtask : t_reg

  task automatic t_swap();
    do_op(3'h4, 8'h00, 7'h22, 1'b0);
    do_op(3'h4, 8'h00, 7'h22, 1'b1);
    do_op(3'h4, 8'h00, 7'h22, 1'b1);
    do_op(3'h4, 8'h00, 7'h22, 1'b0);
  endtask : t_swap

  // Unused codes must leave every output alone, except the done and write strobes, which drop
  task automatic t_refused();
    for (int c = 5; c < 8; c++) do_op(3'(c), 8'h33, 7'h01, 1'b1);
    op_valid_i = 1'b0;
    @(negedge sys_clk_i);
    chk("idle done", 8'h00, done_o);
  endtask : t_refused

  task automatic give_verdict();
    $display("Checks %0d, errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : give_verdict

  initial begin
    for (int i = 0; i < 128; i++) sh[i] = 8'(i) ^ 8'h5a;
    repeat (16) @(negedge sys_clk_i);
    srst_i = 1'b0;
    chk("reset acc", 8'h00, acc_o);
    chk("reset stall", 8'h00, stall_o);
    t_literal();
    t_reg();
    t_swap();
    t_refused();
    give_verdict();
  end
endmodule : alu_subtract_xor_swap_ops_tb

// ==== verification/asx_mem_model.sv ====
// Behavioural data memory that sits behind the ALU slice
`timescale 1ns/1ps
module asx_mem_model (
  // Clock
  input  wire logic       clk_i,
  // Read and write sides
  input  wire logic [6:0] rd_idx_i,
  output logic      [7:0] rd_data_o,
  input  wire logic       we_i,
  input  wire logic [6:0] waddr_i,
  input  wire logic [7:0] wdata_i
);
  logic [7:0] mem [128];
  initial begin
    for (int i = 0; i < 128; i++) mem[i] = 8'(i) ^ 8'h5a;
  end
  // Plain always, since the initial block also fills the array
  always @(posedge clk_i) begin
    if (we_i) mem[waddr_i] <= wdata_i;
  end
  // Write lands one cycle late, so forward it
  assign rd_data_o = (we_i && waddr_i == rd_idx_i) ? wdata_i : mem[rd_idx_i];
endmodule : asx_mem_model
